// ### common/dsio_pkg.sv
// Constants, codes and state type for the direct-store bus logic
package dsio_pkg;
  // Command codes: type[3:0], inverted burst, size[2:0]
  localparam logic [7:0] CMD_LD_REQ = 8'h40;
  localparam logic [7:0] CMD_LD_IMM = 8'h50;
  localparam logic [7:0] CMD_LD_LAST = 8'h70;
  localparam logic [7:0] CMD_ST_IMM = 8'h10;
  localparam logic [7:0] CMD_ST_LAST = 8'h30;
  localparam logic [7:0] CMD_LD_RPLY = 8'hC0;
  localparam logic [7:0] CMD_ST_RPLY = 8'h80;
  // Transfer limits in bytes
  localparam logic [7:0] MAX_BYTES = 8'h80;
  localparam logic [7:0] BEAT_BYTES = 8'h04;
  // Reply address fields
  localparam int REPLY_ERR_BIT = 4;
  localparam int TAG_W = 4;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  // Control fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PID_LSB = 4;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [3:0] CTRL_PID_RST = 4'h0;
  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_STATE_LSB = 4;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARB = 3'h1,
    ST_PKT0 = 3'h3,
    ST_PKT1 = 3'h2,
    ST_DATA = 3'h6,
    ST_REPLY = 3'h7,
    ST_FIN = 3'h5,
    ST_MEM = 3'h4
  } state_t;
endpackage : dsio_pkg

// ### tb/bus_unit_ctrl_model.sv
// Bus unit controller model: grants, acks, load data and the reply
`timescale 1ns/1ps
module bus_unit_ctrl_model (
  // Clock, reset and test controls
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] pid_i,
  input wire logic err_i,
  input wire logic retry_i,
  // From the sequencer
  input wire logic addr_bus_req_n_o,
  input wire logic data_bus_req_n_o,
  input wire logic ext_start_strobe_n_o,
  input wire logic ext_start_strobe_oe_o,
  input wire logic [3:0] xfer_type_lines_o,
  // To the sequencer
  output logic addr_grant_n_i = 1'b1,
  output logic data_grant_n_i = 1'b1,
  output logic addr_ack_n_i = 1'b1,
  output logic addr_retry_n_i = 1'b1,
  output logic xfer_ack_n_i = 1'b1,
  output logic ext_start_strobe_n_i = 1'b1,
  output logic [3:0] xfer_type_lines_i = 4'h0,
  output logic xfer_burst_flag_n_i = 1'b1,
  output logic [2:0] xfer_size_lines_i = 3'h0,
  output logic [31:0] addr_i = 32'h0,
  output logic [31:0] data_upper_lane_i = 32'h0,
  output logic [3:0] data_parity_lane_i = 4'h0
);
  logic last = 1'b0;
  logic ld = 1'b0;
  logic rdone = 1'b0;
  logic [7:0] idx = 8'h00;
  logic [1:0] dly = 2'h0;
  function automatic logic [3:0] par(input logic [31:0] d);
    return {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
  endfunction : par
  ////////////////////////////////////////////////////////////
  // Released address, code and data lines flip every cycle so a stale value never looks valid; acks and strobe return high
  always @(posedge ref_clk_i) begin
    addr_grant_n_i <= addr_bus_req_n_o;
    data_grant_n_i <= data_bus_req_n_o;
    {addr_ack_n_i, addr_retry_n_i, xfer_ack_n_i, ext_start_strobe_n_i} <= 4'hF;
    {xfer_type_lines_i, xfer_burst_flag_n_i, xfer_size_lines_i} <= ~{xfer_type_lines_i, xfer_burst_flag_n_i, xfer_size_lines_i};
    addr_i <= ~addr_i;
    data_upper_lane_i <= ~data_upper_lane_i;
    data_parity_lane_i <= ~data_parity_lane_i;
    rdone <= retry_i & rdone;
    if (!ext_start_strobe_n_o && ext_start_strobe_oe_o) begin
      addr_ack_n_i <= 1'b0;
      addr_retry_n_i <= !(retry_i && !rdone);
      rdone <= retry_i;
      last <= xfer_type_lines_o[1];
      ld <= xfer_type_lines_o[2];
      if (xfer_type_lines_o == 4'h4) idx <= 8'h00;
    end
    if (!data_grant_n_i && !data_bus_req_n_o && xfer_ack_n_i) begin
      xfer_ack_n_i <= 1'b0;
      data_upper_lane_i <= {24'h5A5A00, idx};
      data_parity_lane_i <= par({24'h5A5A00, idx});
      idx <= idx + 8'h01;
      if (last) dly <= 2'h3;
    end
    if (dly != 2'h0) dly <= dly - 2'h1;
    if (dly == 2'h1) begin
      ext_start_strobe_n_i <= 1'b0;
      // Code bit 3 travels as the negated burst pin level
      {xfer_type_lines_i, xfer_burst_flag_n_i, xfer_size_lines_i} <=
        (ld ? dsio_pkg::CMD_LD_RPLY : dsio_pkg::CMD_ST_RPLY) ^ 8'h08;
      addr_i <= {27'h0, err_i, pid_i};
    end
    if (rst_i) dly <= 2'h0;
  end
endmodule : bus_unit_ctrl_model

// ### tb/tb.sv
// Self-checking bench for the direct-store bus sequencer
`timescale 1ns/1ps
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic req_valid_i = 1'b0, req_store_i = 1'b0, req_io_seg_i = 1'b0, req_key_i = 1'b0, mem_done_i = 1'b0;
  logic [31:0] req_seg_i = 32'h0, req_ea_i = 32'h0, st_data_i = 32'h0, rd;
  logic [7:0] req_count_i = 8'h00;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic req_ready_o, st_take_o, ld_valid_o, done_o, err_o, mem_start_o, addr_bus_req_n_o, data_bus_req_n_o;
  logic ext_start_strobe_n_o, ext_start_strobe_oe_o, addr_bus_busy_n_o, addr_bus_busy_oe_o, data_oe_o;
  logic [31:0] ld_data_o, addr_o, data_upper_lane_o, s_axi_rdata, addr_i, data_upper_lane_i;
  logic [3:0] xfer_type_lines_o, data_parity_lane_o, xfer_type_lines_i, data_parity_lane_i, pid_i = 4'h0;
  logic [2:0] xfer_size_lines_o, xfer_size_lines_i;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, xfer_burst_flag_n_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic addr_grant_n_i, data_grant_n_i, addr_ack_n_i, addr_retry_n_i, xfer_ack_n_i;
  logic ext_start_strobe_n_i, xfer_burst_flag_n_i, err_i = 1'b0, retry_i = 1'b0, en = 1'b1;
  logic [7:0] codes[$];
  int errors = 0, checked = 0, cyc = 0, nst = 0, nld = 0, nmem = 0;
  direct_store_bus_io dut_u (.*);
  bus_unit_ctrl_model partner_u (.*);
  always #20 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    @(posedge ref_clk_i);
  endtask : axw
  task automatic axr(input logic [31:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    @(posedge ref_clk_i);
  endtask : axr
  // One core access; retry r makes the first operation go out twice
  task automatic acc(input logic st, input logic io, input logic [7:0] n, input logic e, input logic r);
    int b;
    logic bad;
    logic [7:0] q[$];
    b = (int'(n) + 3) / 4;
    bad = io && (n == 8'h00 || n > dsio_pkg::MAX_BYTES || !en);
    if (io && !bad) begin
      if (!st) q.push_back(dsio_pkg::CMD_LD_REQ);
      for (int i = 1; i <= b; i++) begin
        if (i == b) q.push_back(st ? dsio_pkg::CMD_ST_LAST : dsio_pkg::CMD_LD_LAST);
        else q.push_back(st ? dsio_pkg::CMD_ST_IMM : dsio_pkg::CMD_LD_IMM);
      end
      if (r) q.push_front(q[0]);
    end
    {nst, nld, nmem} = {32'h0, 32'h0, 32'h0};
    codes.delete();
    {req_store_i, req_io_seg_i, req_count_i, err_i, retry_i, req_valid_i} <= {st, io, n, e, r, 1'b1};
    {req_seg_i, req_ea_i} <= {$urandom, $urandom};
    req_key_i <= 1'($urandom);
    do @(posedge ref_clk_i); while (!req_ready_o);
    req_valid_i <= 1'b0;
    do @(posedge ref_clk_i); while (!done_o);
    chk(32'(err_o), 32'(bad || (io && e)));
    chk(32'(codes.size()), 32'(q.size()));
    foreach (q[i]) chk(32'(codes[i]), 32'(q[i]));
    chk(32'(nst), (st && io && !bad) ? 32'(b) : 32'h0);
    chk(32'(nld), (!st && io && !bad) ? 32'(b) : 32'h0);
    chk(32'(nmem), 32'(!io));
  endtask : acc
  ////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    mem_done_i <= mem_start_o;
    if (!ext_start_strobe_n_o && ext_start_strobe_oe_o) begin
      codes.push_back({xfer_type_lines_o, ~xfer_burst_flag_n_o, xfer_size_lines_o});
      chk(32'(addr_bus_busy_n_o), 32'h0);
      chk(addr_o, {2'b00, req_key_i, req_seg_i[28:4], pid_i});
    end
    if (ld_valid_o) chk(ld_data_o, {24'h5A5A00, nld[7:0]});
    if (data_oe_o && !xfer_ack_n_i) chk({data_parity_lane_o, data_upper_lane_o},
      {partner_u.par(st_data_i), st_data_i});
    nld += int'(ld_valid_o);
    nst += int'(st_take_o);
    nmem += int'(mem_start_o);
    if (st_take_o) st_data_i <= $urandom;
    cyc++;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h8803));
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    for (int i = 0; i < 4; i++) begin
      axr(i < 3 ? 32'(i * 4) : 32'h10);
      chk({30'h0, rsp}, i == 3 ? 32'h3 : 32'h0);
      if (i < 3) chk(rd, i == 0 ? 32'h1 : 32'h0);
    end
    axw(32'h4, 32'hFFFFFFFF);
    axr(32'h4);
    chk({rd[31:2], rsp}, 32'h0);
    pid_i <= 4'($urandom);
    @(posedge ref_clk_i);
    axw(32'h0, {24'h0, pid_i, 4'h1});
    acc(1'b1, 1'b1, 8'h01, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 8'h80, 1'b0, 1'b0);
    acc(1'b1, 1'b1, 8'h80, 1'b1, 1'b0);
    acc(1'b1, 1'b1, 8'h08, 1'b0, 1'b1);
    acc(1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 8'h05, 1'b1, 1'b1);
    acc(1'b1, 1'b1, 8'h81, 1'b0, 1'b0);
    acc(1'b1, 1'b0, 8'h10, 1'b0, 1'b0);
    axw(32'h0, {24'h0, pid_i, 4'h0});
    en = 1'b0;
    acc(1'b1, 1'b1, 8'h04, 1'b0, 1'b0);
    en = 1'b1;
    axw(32'h0, {24'h0, pid_i, 4'h1});
    repeat (24) acc(1'($urandom), $urandom_range(0, 3) != 0, 8'($urandom_range(1, 128)), $urandom_range(0, 4) == 0, 1'b0);
    final_report();
  end
endmodule : tb

// ### verilog/direct_store_bus_io.sv
// Direct-store bus sequencer with AXI4-Lite control registers
`timescale 1ns/1ps
module direct_store_bus_io (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Core request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_store_i,
  input wire logic req_io_seg_i,
  input wire logic req_key_i,
  input wire logic [31:0] req_seg_i,
  input wire logic [31:0] req_ea_i,
  input wire logic [7:0] req_count_i,
  input wire logic [31:0] st_data_i,
  output logic st_take_o,
  output logic [31:0] ld_data_o,
  output logic ld_valid_o,
  output logic done_o,
  output logic err_o,
  // Ordinary memory path
  output logic mem_start_o,
  input wire logic mem_done_i,
  // Arbitration
  output logic addr_bus_req_n_o,
  input wire logic addr_grant_n_i,
  output logic data_bus_req_n_o,
  input wire logic data_grant_n_i,
  // Address tenure
  output logic ext_start_strobe_n_o,
  output logic ext_start_strobe_oe_o,
  input wire logic ext_start_strobe_n_i,
  output logic addr_bus_busy_n_o,
  output logic addr_bus_busy_oe_o,
  output logic [31:0] addr_o,
  input wire logic [31:0] addr_i,
  output logic [3:0] xfer_type_lines_o,
  output logic xfer_burst_flag_n_o,
  output logic [2:0] xfer_size_lines_o,
  input wire logic [3:0] xfer_type_lines_i,
  input wire logic xfer_burst_flag_n_i,
  input wire logic [2:0] xfer_size_lines_i,
  input wire logic addr_ack_n_i,
  input wire logic addr_retry_n_i,
  // Data tenure, upper lane only
  output logic [31:0] data_upper_lane_o,
  output logic [3:0] data_parity_lane_o,
  output logic data_oe_o,
  input wire logic [31:0] data_upper_lane_i,
  input wire logic [3:0] data_parity_lane_i,
  input wire logic xfer_ack_n_i,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [3:0] lane_parity(input logic [31:0] d);
    lane_parity = {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
  endfunction : lane_parity

  function automatic logic [2:0] beat_of(input logic [7:0] rem);
    beat_of = (rem > dsio_pkg::BEAT_BYTES) ? 3'h4 : rem[2:0];
  endfunction : beat_of

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  dsio_pkg::state_t state, next_state;
  logic is_load, next_is_load, key, next_key, req_sent, next_req_sent;
  logic dgr, next_dgr, perr, next_perr, io_op, next_io_op, last_err, next_last_err;
  logic [31:0] seg, next_seg, ea, next_ea;
  logic [7:0] total, next_total, remain, next_remain;
  logic [15:0] ops_count, next_ops_count;
  logic ctrl_en;
  logic [3:0] pid;
  logic next_req_ready, next_st_take, next_ld_valid, next_done, next_err, next_mem_start;
  logic next_abr_n, next_dbr_n, next_xs_n, next_xs_oe, next_abb_n, next_abb_oe, next_doe;
  logic [31:0] next_addr, next_ld_data, next_dout;
  logic [3:0] next_dpar;
  logic [7:0] next_code, cur_cmd, snoop_cmd, exp_reply;
  logic [2:0] beat;
  logic addr_only, reply_hit;

  always_comb begin
    beat = beat_of(remain);
    addr_only = is_load && !req_sent;
    if (addr_only) begin
      cur_cmd = dsio_pkg::CMD_LD_REQ;
    end else if (is_load) begin
      cur_cmd = (remain <= dsio_pkg::BEAT_BYTES) ? dsio_pkg::CMD_LD_LAST : dsio_pkg::CMD_LD_IMM;
    end else begin
      cur_cmd = (remain <= dsio_pkg::BEAT_BYTES) ? dsio_pkg::CMD_ST_LAST : dsio_pkg::CMD_ST_IMM;
    end
    // Burst pin carries the inverted code bit on snoop; on drive it is forced negated
    snoop_cmd = {xfer_type_lines_i, ~xfer_burst_flag_n_i, xfer_size_lines_i};
    exp_reply = is_load ? dsio_pkg::CMD_LD_RPLY : dsio_pkg::CMD_ST_RPLY;
    // Reply is only examined while the incoming strobe is asserted
    reply_hit = !ext_start_strobe_n_i && snoop_cmd == exp_reply && addr_i[3:0] == pid;
  end

  always_comb begin
    next_state = state;
    next_is_load = is_load;
    next_key = key;
    next_req_sent = req_sent;
    next_dgr = dgr;
    next_perr = perr;
    next_io_op = io_op;
    next_last_err = last_err;
    next_seg = seg;
    next_ea = ea;
    next_total = total;
    next_remain = remain;
    next_ops_count = ops_count;
    next_req_ready = req_ready_o;
    next_st_take = 1'b0;
    next_ld_valid = 1'b0;
    next_ld_data = ld_data_o;
    next_done = 1'b0;
    next_err = err_o;
    next_mem_start = 1'b0;
    next_abr_n = addr_bus_req_n_o;
    next_dbr_n = data_bus_req_n_o;
    next_xs_n = 1'b1;
    next_xs_oe = 1'b0;
    next_abb_n = 1'b1;
    next_abb_oe = 1'b0;
    next_addr = addr_o;
    next_code = {xfer_type_lines_o, xfer_burst_flag_n_o, xfer_size_lines_o};
    next_doe = 1'b0;
    next_dout = data_upper_lane_o;
    next_dpar = data_parity_lane_o;
    case (state)
      dsio_pkg::ST_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          next_req_ready = 1'b0;
          next_is_load = !req_store_i;
          next_key = req_key_i;
          next_seg = req_seg_i;
          next_ea = req_ea_i;
          next_total = req_count_i;
          next_remain = req_count_i;
          next_req_sent = 1'b0;
          next_perr = 1'b0;
          next_io_op = req_io_seg_i;
          if (!req_io_seg_i) begin
            next_mem_start = 1'b1;
            next_state = dsio_pkg::ST_MEM;
          end else if (!ctrl_en || req_count_i == 8'h00 || req_count_i > dsio_pkg::MAX_BYTES) begin
            next_err = 1'b1;
            next_state = dsio_pkg::ST_FIN;
          end else begin
            next_abr_n = 1'b0;
            next_state = dsio_pkg::ST_ARB;
          end
        end
      end
      dsio_pkg::ST_ARB: begin
        if (!addr_grant_n_i) begin
          next_abr_n = 1'b1;
          next_xs_n = 1'b0;
          next_xs_oe = 1'b1;
          next_abb_n = 1'b0;
          next_abb_oe = 1'b1;
          next_addr = {2'b00, key, seg[28:4], pid};
          next_code = cur_cmd;
          next_state = dsio_pkg::ST_PKT0;
        end
      end
      dsio_pkg::ST_PKT0: begin
        next_xs_oe = 1'b1;
        next_abb_n = 1'b0;
        next_abb_oe = 1'b1;
        next_addr = {seg[3:0], ea[27:0]};
        next_code = addr_only ? total : {5'h00, beat};
        next_state = dsio_pkg::ST_PKT1;
      end
      dsio_pkg::ST_PKT1: begin
        next_xs_oe = 1'b1;
        next_abb_n = 1'b0;
        next_abb_oe = 1'b1;
        if (!addr_ack_n_i) begin
          // Strobe and busy float together when the tenure ends
          next_xs_oe = 1'b0;
          next_abb_n = 1'b1;
          next_abb_oe = 1'b0;
          if (!addr_retry_n_i) begin
            next_abr_n = 1'b0;
            next_state = dsio_pkg::ST_ARB;
          end else if (addr_only) begin
            next_req_sent = 1'b1;
            next_abr_n = 1'b0;
            next_state = dsio_pkg::ST_ARB;
          end else begin
            next_dbr_n = 1'b0;
            next_dgr = 1'b0;
            next_state = dsio_pkg::ST_DATA;
          end
        end
      end
      dsio_pkg::ST_DATA: begin
        next_doe = data_oe_o;
        if (!dgr && !data_grant_n_i) begin
          next_dgr = 1'b1;
          next_dbr_n = 1'b1;
          next_doe = !is_load;
          next_dout = st_data_i;
          next_dpar = lane_parity(st_data_i);
        end else if (dgr && !xfer_ack_n_i) begin
          // Single beat then release: no burst is ever issued
          next_doe = 1'b0;
          next_remain = remain - {5'h00, beat};
          next_ea = ea + {29'h0, beat};
          if (is_load) begin
            next_ld_data = data_upper_lane_i;
            next_ld_valid = 1'b1;
            next_perr = perr | (lane_parity(data_upper_lane_i) != data_parity_lane_i);
          end else begin
            next_st_take = 1'b1;
          end
          if (remain <= dsio_pkg::BEAT_BYTES) begin
            next_state = dsio_pkg::ST_REPLY;
          end else begin
            next_abr_n = 1'b0;
            next_state = dsio_pkg::ST_ARB;
          end
        end
      end
      dsio_pkg::ST_REPLY: begin
        if (reply_hit) begin
          next_err = addr_i[dsio_pkg::REPLY_ERR_BIT] | perr;
          next_state = dsio_pkg::ST_FIN;
        end
      end
      dsio_pkg::ST_FIN: begin
        // Loaded words stay uncommitted by the core unless err_o is low here
        next_done = 1'b1;
        next_last_err = err_o;
        next_ops_count = ops_count + 16'h0001;
        next_req_ready = 1'b1;
        next_state = dsio_pkg::ST_IDLE;
      end
      dsio_pkg::ST_MEM: begin
        if (mem_done_i) begin
          next_err = 1'b0;
          next_state = dsio_pkg::ST_FIN;
        end
      end
      default: begin
        next_state = dsio_pkg::ST_IDLE;
      end
    endcase
    // Every path into ST_FIN sets err_o, so it stays valid with done_o
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= dsio_pkg::ST_IDLE;
      {is_load, key, req_sent, dgr, perr, io_op, last_err} <= 7'h00;
      {seg, ea} <= 64'h0;
      {total, remain} <= 16'h0;
      ops_count <= 16'h0;
      {req_ready_o, st_take_o, ld_valid_o, done_o, err_o, mem_start_o} <= 6'h20;
      ld_data_o <= 32'h0;
      {addr_bus_req_n_o, data_bus_req_n_o, ext_start_strobe_n_o, addr_bus_busy_n_o} <= 4'hF;
      {ext_start_strobe_oe_o, addr_bus_busy_oe_o, data_oe_o} <= 3'h0;
      addr_o <= 32'h0;
      {xfer_type_lines_o, xfer_burst_flag_n_o, xfer_size_lines_o} <= 8'h08;
      data_upper_lane_o <= 32'h0;
      data_parity_lane_o <= 4'h0;
    end else if (ce_i) begin
      state <= next_state;
      {is_load, key, req_sent, dgr, perr, io_op, last_err} <=
        {next_is_load, next_key, next_req_sent, next_dgr, next_perr, next_io_op, next_last_err};
      {seg, ea} <= {next_seg, next_ea};
      {total, remain} <= {next_total, next_remain};
      ops_count <= next_ops_count;
      {req_ready_o, st_take_o, ld_valid_o, done_o, err_o, mem_start_o} <=
        {next_req_ready, next_st_take, next_ld_valid, next_done, next_err, next_mem_start};
      ld_data_o <= next_ld_data;
      {addr_bus_req_n_o, data_bus_req_n_o, ext_start_strobe_n_o, addr_bus_busy_n_o} <=
        {next_abr_n, next_dbr_n, next_xs_n, next_abb_n};
      {ext_start_strobe_oe_o, addr_bus_busy_oe_o, data_oe_o} <= {next_xs_oe, next_abb_oe, next_doe};
      addr_o <= next_addr;
      // Burst pin is forced negated for every command
      {xfer_type_lines_o, xfer_burst_flag_n_o, xfer_size_lines_o} <= {next_code[7:4], 1'b1, next_code[2:0]};
      data_upper_lane_o <= next_dout;
      data_parity_lane_o <= next_dpar;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave
  logic next_ctrl_en, next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [3:0] next_pid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  always_comb begin
    next_ctrl_en = ctrl_en;
    next_pid = pid;
    next_awready = 1'b0;
    next_wready = 1'b0;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    // Write taken only with both channels present and no response pending
    if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
      next_awready = 1'b1;
      next_wready = 1'b1;
      next_bvalid = 1'b1;
      next_bresp = dsio_pkg::RESP_OKAY;
      if (s_axi_awaddr[3:0] == dsio_pkg::OFS_CTRL && s_axi_awaddr[31:4] == 28'h0) begin
        if (s_axi_wstrb[0]) begin
          next_ctrl_en = s_axi_wdata[dsio_pkg::CTRL_EN_BIT];
          next_pid = s_axi_wdata[dsio_pkg::CTRL_PID_LSB +: 4];
        end
      end else if (!(s_axi_awaddr[3:0] == dsio_pkg::OFS_STATUS || s_axi_awaddr[3:0] == dsio_pkg::OFS_COUNT)
                   || s_axi_awaddr[31:4] != 28'h0) begin
        next_bresp = dsio_pkg::RESP_DECERR;
      end
    end
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'b1;
      next_rvalid = 1'b1;
      next_rresp = dsio_pkg::RESP_OKAY;
      next_rdata = 32'h0;
      if (s_axi_araddr[31:4] != 28'h0) begin
        next_rresp = dsio_pkg::RESP_DECERR;
      end else if (s_axi_araddr[3:0] == dsio_pkg::OFS_CTRL) begin
        next_rdata[dsio_pkg::CTRL_EN_BIT] = ctrl_en;
        next_rdata[dsio_pkg::CTRL_PID_LSB +: 4] = pid;
      end else if (s_axi_araddr[3:0] == dsio_pkg::OFS_STATUS) begin
        next_rdata[dsio_pkg::STAT_BUSY_BIT] = !req_ready_o;
        next_rdata[dsio_pkg::STAT_ERR_BIT] = last_err;
        next_rdata[dsio_pkg::STAT_STATE_LSB +: 3] = state;
      end else if (s_axi_araddr[3:0] == dsio_pkg::OFS_COUNT) begin
        next_rdata[15:0] = ops_count;
      end else begin
        next_rresp = dsio_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_en <= dsio_pkg::CTRL_EN_RST;
      pid <= dsio_pkg::CTRL_PID_RST;
      {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid} <= 5'h00;
      {s_axi_bresp, s_axi_rresp} <= 4'h0;
      s_axi_rdata <= 32'h0;
    end else if (ce_i) begin
      ctrl_en <= next_ctrl_en;
      pid <= next_pid;
      {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid} <=
        {next_awready, next_wready, next_bvalid, next_arready, next_rvalid};
      {s_axi_bresp, s_axi_rresp} <= {next_bresp, next_rresp};
      s_axi_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  a_io_goes_arb: assert property (req_valid_i && req_ready_o && req_io_seg_i && ctrl_en &&
    req_count_i != 8'h00 && req_count_i <= dsio_pkg::MAX_BYTES |=> state == dsio_pkg::ST_ARB)
    else $error("io request did not start arbitration");
  a_mem_path_start: assert property (req_valid_i && req_ready_o && !req_io_seg_i |=> mem_start_o)
    else $error("memory request not handed on");
  a_mem_no_strobe: assert property (state == dsio_pkg::ST_MEM |-> ext_start_strobe_n_o && !ext_start_strobe_oe_o)
    else $error("extended strobe during memory access");
  a_strobe_one_clk: assert property (!ext_start_strobe_n_o |-> !addr_bus_busy_n_o ##1
    (ext_start_strobe_n_o && ext_start_strobe_oe_o && !addr_bus_busy_n_o))
    else $error("strobe not one clock with busy");
  a_release_together: assert property (ext_start_strobe_oe_o == addr_bus_busy_oe_o)
    else $error("strobe and busy released apart");
  a_two_beats: assert property (state == dsio_pkg::ST_PKT0 |=> state == dsio_pkg::ST_PKT1 &&
    addr_o[31:28] == seg[3:0])
    else $error("second address beat missing");
  a_no_burst: assert property (addr_bus_busy_oe_o |-> xfer_burst_flag_n_o)
    else $error("burst flag asserted");
  a_upper_store_only: assert property (data_oe_o |-> state == dsio_pkg::ST_DATA && !is_load)
    else $error("data driven outside store beat");
  a_one_at_time: assert property (state != dsio_pkg::ST_IDLE |-> !req_ready_o)
    else $error("new request accepted before reply");
  a_reply_status: assert property (state == dsio_pkg::ST_REPLY && reply_hit |=> state == dsio_pkg::ST_FIN
    ##1 (done_o && err_o == $past(addr_i[dsio_pkg::REPLY_ERR_BIT] | perr, 2)))
    else $error("reply status not reported");
endmodule : direct_store_bus_io
